// >>> shared/ctp_pkg.sv
// constants and types shared by the control port slave
`default_nettype none
package ctp_pkg;

    // ------------------------------------------------------------------
    // register file shape
    // ------------------------------------------------------------------
    localparam int NIB_COUNT = 8;
    localparam int BYTE_COUNT = 16;
    localparam logic [2:0] PTR_ADDR = 3'h7;       // pointer nibble slot

    // read-only bit masks; arbitrary plain defaults
    localparam logic [27:0] NIB_RO_MASK = 28'h00000f0;
    localparam logic [127:0] BYTE_RO_MASK = {8'hff, 120'h0};

    // reset values of the writable storage
    localparam logic [3:0] NIB_RESET = 4'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] PTR_RESET = 4'h0;

    // ------------------------------------------------------------------
    // frame positions, counted in rising shift clock edges
    // ------------------------------------------------------------------
    localparam logic [4:0] POS_DIR = 5'h00;
    localparam logic [4:0] POS_ADDR_FIRST = 5'h01;
    localparam logic [4:0] POS_ADDR_LAST = 5'h03;
    localparam logic [4:0] POS_NIB_FIRST = 5'h04;
    localparam logic [4:0] POS_NIB_LAST = 5'h07;
    localparam logic [4:0] POS_BYTE_FIRST = 5'h08;
    localparam logic [4:0] POS_BYTE_LAST = 5'h0f;
    localparam logic [4:0] SPLIT_OFFSET = 5'h08;

    // consecutive high samples that enter the float mode
    localparam logic [5:0] FLOAT_EDGES = 6'h21;

    // direction flag values
    localparam logic DIR_READ = 1'b1;
    localparam logic DIR_WRITE = 1'b0;

    // completed write handed from the port to the core domain
    typedef struct packed {
        logic is_byte;
        logic [3:0] addr;
        logic [7:0] data;
    } ctp_wr_t;

endpackage
`default_nettype wire

// >>> hw/ctp_control_port.sv
// serial control port slave with core-domain register file
`default_nettype none
// Function
// - select low starts a frame; first sampled bit: 1 read, 0 write
// - seven nibble registers plus the pointer slot and sixteen byte registers, bytes reached indirectly
// - three address bits follow, msb first, choosing a nibble register
// - nibble read drives four bits msb first on following falling edges
// - serial input ignored while read data is being driven
// - serial output floats except while shifting read data
// - nibble write captures four bits and stores them, output floating
// - read-only registers and bits stay unchanged on writes
// - address seven stores next four bits as byte pointer, byte access
// - pointer keeps its byte address for the following transaction
// - byte read shifts selected byte msb first on eight falling edges
// - byte access is sixteen bits, continuous or split in two halves
// - split byte read presents msb at once when select falls again
// - bit order identical for continuous and split byte accesses
// - byte write captures eight bits and stores them unless read-only
// - select rising aborts the frame and floats the serial output
// - shift clock is ignored while select is high
// - select low with input high 33 edges floats outputs until exit
module ctp_control_port
    import ctp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic PORT_SHIFT_CLOCK_I,
    input wire logic PORT_SELECT_N_I,
    input wire logic PORT_SERIAL_IN_I,
    output logic PORT_SERIAL_OUT_O,
    output logic PORT_SERIAL_OUT_OE_O,
    output logic ALL_OUTPUTS_FLOAT_MODE_O,
    input wire logic [27:0] NIBBLE_STATUS_I,
    input wire logic [127:0] BYTE_STATUS_I,
    output logic [27:0] NIBBLE_REGS_O,
    output logic [127:0] BYTE_REGS_O
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // merge new bits over old ones, keeping read-only bits
    function automatic logic [7:0] keep_ro(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic [7:0] ro);
        keep_ro = (old_v & ro) | (new_v & ~ro);
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic lrst_n;
    logic [4:0] cnt_q;
    logic dir_q;
    logic [2:0] addr_q;
    logic [7:0] shift_q;
    logic done_q;
    logic own_q;
    logic [5:0] float_cnt_q;
    logic [3:0] ptr_q;
    logic pend_q;
    logic bdir_q;
    logic wr_tgl_q;
    ctp_wr_t wr_q;
    logic sout_q;
    logic oe_q;
    logic [3:0] snap_nib [NIB_COUNT];
    logic [7:0] snap_byt [BYTE_COUNT];
    logic [3:0] nib_q [NIB_COUNT];
    logic [7:0] byt_q [BYTE_COUNT];
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic sel_s1_q;
    logic sel_s2_q;
    logic flt_s1_q;
    logic flt_s2_q;
    logic float_out_q;

    // ------------------------------------------------------------------
    // link-side decode
    // ------------------------------------------------------------------
    // select high holds the frame logic in reset: abort and clock ignore
    assign lrst_n = RST_B_I & ~PORT_SELECT_N_I;

    wire split_w = pend_q & ~own_q;                 // second half of split
    wire [4:0] pos_w = split_w ? 5'(cnt_q + SPLIT_OFFSET) : cnt_q;
    wire is_byte_w = split_w | (addr_q == PTR_ADDR);
    wire rd_dir_w = split_w ? bdir_q : dir_q;
    wire in_nib_w = (pos_w >= POS_NIB_FIRST) && (pos_w <= POS_NIB_LAST);
    wire in_byte_w = (pos_w >= POS_BYTE_FIRST) && (pos_w <= POS_BYTE_LAST);

    // read data phase: nibble slots or byte slots after the pointer
    wire rd_phase_w = ~done_q & (rd_dir_w == DIR_READ) &
                      (is_byte_w ? in_byte_w : in_nib_w);

    // bit index counts down, so both frame shapes go msb first
    wire [2:0] byte_idx_w = 3'(POS_BYTE_LAST - pos_w);
    wire [1:0] nib_idx_w = 2'(POS_NIB_LAST - pos_w);
    wire rd_bit_w = is_byte_w ? snap_byt[ptr_q][byte_idx_w]
                              : snap_nib[addr_q][nib_idx_w];

    // split byte read: msb shown as soon as select falls again
    // gated by select so the pending half never drives while deselected
    wire imm_w = split_w & ~PORT_SELECT_N_I & (cnt_q == POS_DIR) &
                 rd_phase_w;

    // input is taken only while the port is not talking
    wire take_w = ~done_q & ~rd_phase_w;
    wire [7:0] shin_w = {shift_q[6:0], PORT_SERIAL_IN_I};

    // float mode: level, left when select rises or input falls
    wire float_w = (float_cnt_q >= FLOAT_EDGES) & PORT_SERIAL_IN_I;

    // write completion points
    wire nib_end_w = ~split_w & (pos_w == POS_NIB_LAST);
    wire byte_end_w = is_byte_w & (pos_w == POS_BYTE_LAST);
    wire ptr_end_w = nib_end_w & (addr_q == PTR_ADDR);

    // ------------------------------------------------------------------
    // frame state, cleared by select high
    // ------------------------------------------------------------------
    // direction, address and data shifting on rising edges
    always_ff @(posedge PORT_SHIFT_CLOCK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            cnt_q <= POS_DIR;
            dir_q <= DIR_WRITE;
            addr_q <= 3'h0;
            shift_q <= 8'h00;
            done_q <= 1'b0;
            own_q <= 1'b0;
        end else begin
            if (!done_q) begin
                cnt_q <= 5'(cnt_q + 5'h01);
            end
            if (take_w) begin
                shift_q <= shin_w;
            end
            if (!done_q && !split_w && pos_w == POS_DIR) begin
                dir_q <= PORT_SERIAL_IN_I;
            end
            if (!done_q && pos_w >= POS_ADDR_FIRST &&
                pos_w <= POS_ADDR_LAST) begin
                addr_q <= {addr_q[1:0], PORT_SERIAL_IN_I};
            end
            if (ptr_end_w) begin
                own_q <= 1'b1;  // this frame continues as the byte part
            end
            // nibble access ends after its data, byte after sixteen
            if ((nib_end_w && !ptr_end_w) || byte_end_w) begin
                done_q <= 1'b1;
            end
        end
    end

    // consecutive high samples while selected
    always_ff @(posedge PORT_SHIFT_CLOCK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            float_cnt_q <= 6'h00;
        end else if (!PORT_SERIAL_IN_I) begin
            float_cnt_q <= 6'h00;
        end else if (float_cnt_q < FLOAT_EDGES) begin
            float_cnt_q <= 6'(float_cnt_q + 6'h01);
        end
    end

    // ------------------------------------------------------------------
    // state that outlives a frame: pointer and write hand-off
    // ------------------------------------------------------------------
    // only the device reset clears these; select must not lose them
    always_ff @(posedge PORT_SHIFT_CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ptr_q <= PTR_RESET;
            pend_q <= 1'b0;
            bdir_q <= DIR_WRITE;
            wr_tgl_q <= 1'b0;
            wr_q <= '0;
        end else if (!PORT_SELECT_N_I) begin
            if (ptr_end_w) begin
                ptr_q <= shin_w[3:0];
                pend_q <= 1'b1;
                bdir_q <= dir_q;
            end else if (nib_end_w && dir_q == DIR_WRITE) begin
                wr_q <= '{is_byte: 1'b0, addr: {1'b0, addr_q},
                          data: {4'h0, shin_w[3:0]}};
                wr_tgl_q <= ~wr_tgl_q;
            end
            if (byte_end_w) begin
                pend_q <= 1'b0;
                if (rd_dir_w == DIR_WRITE) begin
                    wr_q <= '{is_byte: 1'b1, addr: ptr_q,
                              data: shin_w};
                    wr_tgl_q <= ~wr_tgl_q;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // read data out on falling edges
    // ------------------------------------------------------------------
    // launching on the falling edge gives the master half a period
    always_ff @(negedge PORT_SHIFT_CLOCK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            sout_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            sout_q <= rd_bit_w;
            oe_q <= rd_phase_w;
        end
    end

    // enable drops at once with select; float mode overrides it
    assign PORT_SERIAL_OUT_OE_O = (oe_q | imm_w) & ~float_w;
    assign PORT_SERIAL_OUT_O = imm_w ? rd_bit_w : sout_q;

    // ------------------------------------------------------------------
    // core domain: synchronisers
    // ------------------------------------------------------------------
    // write toggle and select each pass two flops, float level three
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            sel_s1_q <= 1'b1;
            sel_s2_q <= 1'b1;
            flt_s1_q <= 1'b0;
            flt_s2_q <= 1'b0;
            float_out_q <= 1'b0;
        end else begin
            tgl_s1_q <= wr_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
            sel_s1_q <= PORT_SELECT_N_I;
            sel_s2_q <= sel_s1_q;
            flt_s1_q <= float_w;
            flt_s2_q <= flt_s1_q;
            float_out_q <= flt_s2_q;
        end
    end

    wire wr_evt_w = tgl_s2_q ^ tgl_s3_q;
    assign ALL_OUTPUTS_FLOAT_MODE_O = float_out_q;

    // ------------------------------------------------------------------
    // core domain: register file
    // ------------------------------------------------------------------
    // payload is stable long before the toggle arrives here
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            for (int i = 0; i < NIB_COUNT; i++) begin
                nib_q[i] <= NIB_RESET;
            end
            for (int j = 0; j < BYTE_COUNT; j++) begin
                byt_q[j] <= BYTE_RESET;
            end
        end else if (wr_evt_w) begin
            if (wr_q.is_byte) begin
                byt_q[wr_q.addr] <= keep_ro(byt_q[wr_q.addr], wr_q.data,
                    BYTE_RO_MASK[wr_q.addr*8 +: 8]);
            end else begin
                nib_q[wr_q.addr[2:0]] <= 4'(keep_ro(
                    {4'h0, nib_q[wr_q.addr[2:0]]}, wr_q.data,
                    {4'hf, NIB_RO_MASK[wr_q.addr[2:0]*4 +: 4]}));
            end
        end
    end

    // snapshot for readback, frozen while the port is selected
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            for (int i = 0; i < NIB_COUNT; i++) begin
                snap_nib[i] <= NIB_RESET;
            end
            for (int j = 0; j < BYTE_COUNT; j++) begin
                snap_byt[j] <= BYTE_RESET;
            end
        end else if (sel_s2_q) begin
            // the pointer slot is never read back, so it stays at reset
            for (int i = 0; i < NIB_COUNT - 1; i++) begin
                snap_nib[i] <= 4'((nib_q[i] & ~NIB_RO_MASK[i*4 +: 4]) |
                    (NIBBLE_STATUS_I[i*4 +: 4] & NIB_RO_MASK[i*4 +: 4]));
            end
            for (int j = 0; j < BYTE_COUNT; j++) begin
                snap_byt[j] <= keep_ro(byt_q[j], BYTE_STATUS_I[j*8 +: 8],
                    ~BYTE_RO_MASK[j*8 +: 8]);
            end
        end
    end

    // control bits toward the rest of the chip
    always_comb begin
        for (int i = 0; i < NIB_COUNT - 1; i++) begin
            NIBBLE_REGS_O[i*4 +: 4] = nib_q[i];
        end
        for (int j = 0; j < BYTE_COUNT; j++) begin
            BYTE_REGS_O[j*8 +: 8] = byt_q[j];
        end
    end

endmodule
`default_nettype wire

// >>> testbench/ctp_chk.sv
// assertion checker on the control port slave pins
`default_nettype none
module ctp_chk
    import ctp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic PORT_SHIFT_CLOCK_I,
    input wire logic PORT_SELECT_N_I,
    input wire logic PORT_SERIAL_IN_I,
    input wire logic PORT_SERIAL_OUT_OE_O,
    input wire logic ALL_OUTPUTS_FLOAT_MODE_O
);
    // ------------------------------------------------------------------
    // frame tracking in the shift clock domain
    // ------------------------------------------------------------------
    wire sck = PORT_SHIFT_CLOCK_I;
    wire oe = PORT_SERIAL_OUT_OE_O;
    wire flt = ALL_OUTPUTS_FLOAT_MODE_O;
    wire off = PORT_SELECT_N_I || !RST_B_I;
    logic [5:0] cnt_q;
    logic [3:0] hdr_q;
    logic pend_q;
    logic pdir_q;
    // edge count and header bits; select high clears the count like the port does
    always_ff @(posedge sck or posedge PORT_SELECT_N_I) begin
        if (PORT_SELECT_N_I) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;
            hdr_q <= (cnt_q < 6'h04) ? {hdr_q[2:0], PORT_SERIAL_IN_I} : hdr_q;
        end
    end
    // pointer taken: byte half pending until its eight bits are done
    always_ff @(posedge sck or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pend_q <= 1'b0;
            pdir_q <= 1'b0;
        end else if (!PORT_SELECT_N_I && cnt_q == 6'h07) begin
            pend_q <= !pend_q && hdr_q[2:0] == PTR_ADDR;
            pdir_q <= hdr_q[3];
        end else if (!PORT_SELECT_N_I && cnt_q == 6'h0f) begin
            pend_q <= 1'b0;
        end
    end
    wire nib_rd = !pend_q && hdr_q[3] && hdr_q[2:0] != PTR_ADDR;
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_sel;
        @(posedge CLK_I) disable iff (!RST_B_I) PORT_SELECT_N_I |-> !oe;
    endproperty
    a_sel: assert property (p_sel) else $error("driving while idle");
    property p_flt;
        @(posedge CLK_I) disable iff (!RST_B_I) flt |-> !oe;
    endproperty
    a_flt: assert property (p_flt) else $error("driving in float");
    property p_hdr;
        @(posedge sck) disable iff (off) !pend_q && cnt_q < 6'h04 |-> !oe;
    endproperty
    a_hdr: assert property (p_hdr) else $error("driving in header");
    property p_nrd;
        @(posedge sck) disable iff (off) nib_rd && cnt_q == 6'h04 |-> oe [*4];
    endproperty
    a_nrd: assert property (p_nrd) else $error("nibble read idle");
    property p_nwr;
        @(posedge sck) disable iff (off)
        !pend_q && !hdr_q[3] && cnt_q >= 6'h04 |-> !oe;
    endproperty
    a_nwr: assert property (p_nwr) else $error("driving in write");
    property p_brd;
        @(posedge sck) disable iff (off)
        pend_q && pdir_q && cnt_q >= 6'h08 |-> oe;
    endproperty
    a_brd: assert property (p_brd) else $error("byte read idle");
    property p_srd;
        @(posedge sck) disable iff (off) pend_q && pdir_q && cnt_q < 6'h08 |-> oe;
    endproperty
    a_srd: assert property (p_srd) else $error("split read idle");
    property p_bwr;
        @(posedge sck) disable iff (off) pend_q && !pdir_q |-> !oe;
    endproperty
    a_bwr: assert property (p_bwr) else $error("byte write drive");
    // main scenarios reached
    c_split: cover property (@(posedge sck) pend_q && pdir_q && cnt_q == 6'h00);
    c_bwr: cover property (@(posedge sck) pend_q && !pdir_q);
    c_float: cover property (@(posedge CLK_I) flt);
endmodule
bind ctp_control_port ctp_chk u_ctp_chk (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I),
    .PORT_SHIFT_CLOCK_I(PORT_SHIFT_CLOCK_I),
    .PORT_SELECT_N_I(PORT_SELECT_N_I), .PORT_SERIAL_IN_I(PORT_SERIAL_IN_I),
    .PORT_SERIAL_OUT_OE_O(PORT_SERIAL_OUT_OE_O),
    .ALL_OUTPUTS_FLOAT_MODE_O(ALL_OUTPUTS_FLOAT_MODE_O)
);
`default_nettype wire

// >>> testbench/ctp_master.sv
// partner model: serial master clocking frames into the port
`default_nettype none
module ctp_master (
    output logic shift_clk_o,
    output logic select_n_o,
    output logic serial_o,
    input wire logic serial_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: deselected, clock parked low between frames
    initial begin
        shift_clk_o = 1'b0;
        select_n_o = 1'b1;
        serial_o = 1'b0;
    end
    // n bits msb first on a 6 ns clock; keep leaves select low
    task automatic xfer(input logic [39:0] b, input int n, input bit keep,
                        output logic [39:0] rx);
        rx = '0;
        select_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_o = b[i];
            #3;
            shift_clk_o = 1'b1;
            rx = {rx[38:0], serial_i};
            #2;
            select_n_o = (i == 0) && !keep;
            #1;
            shift_clk_o = 1'b0;
        end
        // released line shows the opposite level, not the last bit
        if (!keep) serial_o = ~serial_o;
    endtask
    // close a frame that was held open
    task automatic drop();
        select_n_o = 1'b1;
        serial_o = ~serial_o;
    endtask
endmodule
`default_nettype wire

// >>> testbench/test_serial_control_port_slave.sv
// self-checking bench for the control port slave
`default_nettype none
module test_serial_control_port_slave;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [27:0] nstat = 28'h1234567;
    logic [127:0] bstat = {8'hc3, 120'h0};
    logic [39:0] rx;
    logic [3:0] d;
    int mismatches = 0;
    int num_checks = 0;
    wire sck, sel_n, sdi, sdo, oe, flt;
    wire [27:0] nregs;
    wire [127:0] bregs;
    // undriven line toggles so stale data never reads as valid
    wire line = oe ? sdo : ~sdi;
    ctp_control_port u_ctp_control_port (
        .CLK_I(clk), .RST_B_I(rst_b), .PORT_SHIFT_CLOCK_I(sck),
        .PORT_SELECT_N_I(sel_n), .PORT_SERIAL_IN_I(sdi),
        .PORT_SERIAL_OUT_O(sdo), .PORT_SERIAL_OUT_OE_O(oe),
        .ALL_OUTPUTS_FLOAT_MODE_O(flt), .NIBBLE_STATUS_I(nstat),
        .BYTE_STATUS_I(bstat), .NIBBLE_REGS_O(nregs), .BYTE_REGS_O(bregs)
    );
    ctp_master u_ctp_master (
        .shift_clk_o(sck), .select_n_o(sel_n), .serial_o(sdi), .serial_i(line)
    );
    // core clock 20 MHz
    always #25 clk = ~clk;
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] got,
                       input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // frame after a core edge; long gap lets writes cross and reads refresh
    task automatic frame(input logic [39:0] b, input int n);
        @(posedge clk);
        #2;
        u_ctp_master.xfer(b, n, 1'b0, rx);
        repeat (10) @(posedge clk);
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        #2;
        rst_b = 1'b1;
        repeat (4) @(posedge clk);
        chk("reset regs", {nregs[27:24], nregs[11:8]}, 8'h00);
        for (int a = 0; a < 7; a++) begin
            frame({32'h0, 1'b0, 3'(a), 4'(a) ^ 4'ha}, 8);
        end
        // reads drive a pattern on the input that must be ignored
        for (int a = 0; a < 7; a++) begin
            d = 4'(a) ^ 4'ha;
            frame({32'h0, 1'b1, 3'(a), 4'h5}, 8);
            if (a != 1) begin
                chk("nib reg", {4'h0, nregs[4*a +: 4]}, {4'h0, d});
                chk("nib rd", {4'h0, rx[3:0]}, {4'h0, d});
            end
        end
        frame({32'h0, 8'h90}, 8);
        chk("ro nibble", {4'h0, rx[3:0]}, {4'h0, nstat[7:4]});
        $display("test nibble done");
        frame({32'h0, 8'h0f}, 6);
        frame({32'h0, 8'hb0}, 8);
        chk("abort", {4'h0, rx[3:0]}, 8'h09);
        $display("test abort done");
        frame({24'h0, 8'h75, 8'ha5}, 16);
        chk("byte reg", bregs[47:40], 8'ha5);
        frame({24'h0, 8'hf5, 8'h00}, 16);
        chk("byte rd", rx[7:0], 8'ha5);
        frame({24'h0, 8'h7f, 8'h5a}, 16);
        frame({24'h0, 8'hff, 8'h00}, 16);
        chk("ro byte", rx[7:0], bstat[127:120]);
        $display("test byte done");
        frame({32'h0, 8'h73}, 8);
        frame({32'h0, 8'h3c}, 8);
        chk("split wr", bregs[31:24], 8'h3c);
        frame({32'h0, 8'hf3}, 8);
        frame({32'h0, 8'hff}, 8);
        chk("split rd", rx[7:0], 8'h3c);
        frame({24'h0, 8'hf3, 8'h00}, 16);
        chk("whole rd", rx[7:0], 8'h3c);
        $display("test split done");
        @(posedge clk);
        #2;
        u_ctp_master.xfer({40{1'b1}}, 34, 1'b1, rx);
        repeat (6) @(posedge clk);
        chk("float", {7'h0, flt}, 8'h01);
        u_ctp_master.drop();
        repeat (6) @(posedge clk);
        chk("float exit", {7'h0, flt}, 8'h00);
        $display("test float done");
        summarize();
    end
    // watchdog well beyond the few hundred core cycles of the tests
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
